// ===== design/frame_metadata_embedder.sv
// Purpose: overwrites the first pixel words of each frame with metadata
// Assumes: valid/ready stream, sof marks first word of the frame
// Notes:   metadata spills across line boundaries, roi is only embedded as metadata, never applied
`timescale 1ns/10ps
`default_nettype none
module frame_metadata_embedder
    import meta_embed_pkg::*;
#(
    parameter int PIX_W = 16
)
(
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  embed_enable,
    input  wire logic [NUM_CATS-1:0]   cat_select,
    input  wire logic [31:0]           timestamp,
    input  wire logic [GAIN_BITS-1:0]  gain,
    input  wire logic [31:0]           exposure_us,
    input  wire logic [LEVEL_BITS-1:0] brightness,
    input  wire logic [LEVEL_BITS-1:0] wb_red,
    input  wire logic [LEVEL_BITS-1:0] wb_green,
    input  wire logic [LEVEL_BITS-1:0] wb_blue,
    input  wire logic [31:0]           frame_count,
    input  wire logic [31:0]           trigger_count,
    input  wire logic [31:0]           line_io,
    input  wire logic [15:0]           roi_col,
    input  wire logic [15:0]           roi_row,
    input  wire logic [15:0]           roi_length,
    input  wire logic [15:0]           roi_width,
    input  wire logic [PIX_W-1:0]      in_data,
    input  wire logic                  in_sof,
    input  wire logic                  in_eol,
    input  wire logic                  in_valid,
    output logic                       in_ready,
    output logic [PIX_W-1:0]           out_data,
    output logic                       out_sof,
    output logic                       out_eol,
    output logic                       out_valid,
    input  wire logic                  out_ready
);
    // refused at elaboration: a byte must fit the low bits of a pixel word
    if (PIX_W < BYTE_BITS)
    begin : g_width_check
        $error("pixel word narrower than a byte");
    end

    // ------------------------------------------------------------
    // embedding sequencer
    // ------------------------------------------------------------
    embed_state_t       state_q, state_d;
    logic [3:0]         cat_q, cat_d;
    logic [2:0]         idx_q, idx_d;
    logic [NUM_CATS-1:0] sel_q, sel_d;
    logic [7:0]         meta_byte;
    logic [7:0]         first_byte;
    logic               take;
    logic               embedding;

    // first selected category at or after a given one
    function automatic logic [3:0] next_cat(input logic [NUM_CATS-1:0] sel, input logic [3:0] from);
        logic [3:0] r;
        r = 4'(NUM_CATS);
        for (int i = NUM_CATS - 1; i >= 0; i--)
            if (sel[i] && 4'(i) >= from)
                r = 4'(i);
        return r;
    endfunction

    meta_byte_pick u_pick (
        .cat           (cat_q),
        .idx           (idx_q),
        .timestamp     (timestamp),
        .gain          (gain),
        .exposure_us   (exposure_us),
        .brightness    (brightness),
        .wb_red        (wb_red),
        .wb_green      (wb_green),
        .wb_blue       (wb_blue),
        .frame_count   (frame_count),
        .trigger_count (trigger_count),
        .line_io       (line_io),
        .roi_col       (roi_col),
        .roi_row       (roi_row),
        .roi_length    (roi_length),
        .roi_width     (roi_width),
        .byte_out      (meta_byte)
    );

    // output register stage; stall only when it holds an unaccepted word
    logic [PIX_W-1:0] data_q, data_d;
    logic             sof_q, sof_d, eol_q, eol_d, vld_q, vld_d;

    assign in_ready = !vld_q || out_ready;
    assign take     = in_valid && in_ready;

    always_comb
    begin
        state_d   = state_q;
        cat_d     = cat_q;
        idx_d     = idx_q;
        sel_d     = sel_q;
        embedding = 1'b0;
        case (state_q)
            ST_IDLE, ST_PASS:
            begin
                // selection and enable are sampled once per frame
                if (take && in_sof && embed_enable && cat_select != '0)
                begin
                    sel_d = cat_select;
                    cat_d = next_cat(cat_select, 4'h0);
                    idx_d = '0;
                    state_d = ST_META;
                end
                else if (take && in_sof)
                    state_d = ST_PASS;
            end
            ST_META:
            begin
                if (take && in_sof && !(embed_enable && cat_select != '0))
                    state_d = ST_PASS;
                else if (take && in_sof)
                begin
                    sel_d = cat_select;
                    cat_d = next_cat(cat_select, 4'h0);
                    idx_d = '0;
                end
                else if (take)
                begin
                    // line ends are ignored so the bytes run on into the next line
                    if (4'(idx_q) + 4'h1 == cat_len(cat_q))
                    begin
                        idx_d = '0;
                        cat_d = next_cat(sel_q, cat_q + 4'h1);
                        if (next_cat(sel_q, cat_q + 4'h1) == 4'(NUM_CATS))
                            state_d = ST_PASS;
                    end
                    else
                        idx_d = idx_q + 3'h1;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        // the word being taken carries metadata if the new state says so at sof
        if (take && in_sof)
            embedding = (state_d == ST_META);
        else if (take)
            embedding = (state_q == ST_META);
    end

    always_comb
    begin
        data_d = data_q;
        sof_d  = sof_q;
        eol_d  = eol_q;
        vld_d  = vld_q && !out_ready;
        if (take)
        begin
            vld_d = 1'b1;
            sof_d = in_sof;
            eol_d = in_eol;
            if (embedding && in_sof)
                data_d = {{(PIX_W-BYTE_BITS){1'b0}}, first_byte};
            else if (embedding)
                data_d = {{(PIX_W-BYTE_BITS){1'b0}}, meta_byte};
            else
                data_d = in_data;
        end
    end

    // at sof the picker still points at the old frame, so pick the first byte here
    meta_byte_pick u_pick_first (
        .cat           (next_cat(cat_select, 4'h0)),
        .idx           (3'h0),
        .timestamp     (timestamp),
        .gain          (gain),
        .exposure_us   (exposure_us),
        .brightness    (brightness),
        .wb_red        (wb_red),
        .wb_green      (wb_green),
        .wb_blue       (wb_blue),
        .frame_count   (frame_count),
        .trigger_count (trigger_count),
        .line_io       (line_io),
        .roi_col       (roi_col),
        .roi_row       (roi_row),
        .roi_length    (roi_length),
        .roi_width     (roi_width),
        .byte_out      (first_byte)
    );

    // first byte consumed at sof: advance sequencer one step
    logic [3:0] cat_r;
    logic [2:0] idx_r;
    logic       done_r;
    always_comb
    begin
        cat_r  = cat_d;
        idx_r  = idx_d;
        done_r = 1'b0;
        if (take && in_sof && state_d == ST_META)
        begin
            if (4'h1 == cat_len(cat_d))
            begin
                idx_r  = '0;
                cat_r  = next_cat(sel_d, cat_d + 4'h1);
                done_r = (cat_r == 4'(NUM_CATS));
            end
            else
                idx_r = 3'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            cat_q   <= '0;
            idx_q   <= '0;
            sel_q   <= '0;
            data_q  <= '0;
            sof_q   <= 1'b0;
            eol_q   <= 1'b0;
            vld_q   <= 1'b0;
        end
        else
        begin
            state_q <= done_r ? ST_PASS : state_d;
            cat_q   <= cat_r;
            idx_q   <= idx_r;
            sel_q   <= sel_d;
            data_q  <= data_d;
            sof_q   <= sof_d;
            eol_q   <= eol_d;
            vld_q   <= vld_d;
        end
    end

    assign out_data  = data_q;
    assign out_sof   = sof_q;
    assign out_eol   = eol_q;
    assign out_valid = vld_q;
endmodule
`default_nettype wire

// ===== design/meta_embed_pkg.sv
// Purpose: shared constants for the frame metadata embedder
// Assumes: one metadata byte per pixel word, low eight bits
// Notes:   category numbering follows the transmitted order
`default_nettype none
package meta_embed_pkg;
    localparam int NUM_CATS     = 9;
    localparam int MAX_BYTES    = 8;
    localparam int CAT_TIMESTAMP = 0;
    localparam int CAT_GAIN      = 1;
    localparam int CAT_EXPOSURE  = 2;
    localparam int CAT_BRIGHT    = 3;
    localparam int CAT_WBAL      = 4;
    localparam int CAT_FRAMECNT  = 5;
    localparam int CAT_TRIGCNT   = 6;
    localparam int CAT_LINEIO    = 7;
    localparam int CAT_ROI       = 8;
    localparam logic [3:0] CAT_LEN_SHORT = 4'h4;
    localparam logic [3:0] CAT_LEN_LONG  = 4'h8;
    localparam int GAIN_BITS   = 10;
    localparam int LEVEL_BITS  = 12;
    localparam int HALF_BITS   = 16;
    localparam int BYTE_BITS   = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_META,
        ST_PASS
    } embed_state_t;

    // byte count of each category
    function automatic logic [3:0] cat_len(input logic [3:0] cat);
        cat_len = (cat == 4'(CAT_WBAL) || cat == 4'(CAT_ROI)) ? CAT_LEN_LONG : CAT_LEN_SHORT;
    endfunction
endpackage
`default_nettype wire

// ===== design/meta_byte_pick.sv
// Purpose: selects one metadata byte by category and byte index
// Assumes: values stable for the frame, captured upstream
// Notes:   multi-byte values go most significant byte first
`timescale 1ns/10ps
`default_nettype none
module meta_byte_pick
    import meta_embed_pkg::*;
(
    input  wire logic [3:0]  cat,
    input  wire logic [2:0]  idx,
    input  wire logic [31:0] timestamp,
    input  wire logic [GAIN_BITS-1:0]  gain,
    input  wire logic [31:0] exposure_us,
    input  wire logic [LEVEL_BITS-1:0] brightness,
    input  wire logic [LEVEL_BITS-1:0] wb_red,
    input  wire logic [LEVEL_BITS-1:0] wb_green,
    input  wire logic [LEVEL_BITS-1:0] wb_blue,
    input  wire logic [31:0] frame_count,
    input  wire logic [31:0] trigger_count,
    input  wire logic [31:0] line_io,
    input  wire logic [15:0] roi_col,
    input  wire logic [15:0] roi_row,
    input  wire logic [15:0] roi_length,
    input  wire logic [15:0] roi_width,
    output logic      [7:0]  byte_out
);
    logic [63:0] field;

    always_comb
    begin
        field = '0;
        case (cat)
            4'(CAT_TIMESTAMP): field = {timestamp, 32'h0};
            4'(CAT_GAIN):      field = {{(32-GAIN_BITS){1'b0}}, gain, 32'h0};
            4'(CAT_EXPOSURE):  field = {exposure_us, 32'h0};
            4'(CAT_BRIGHT):    field = {{(32-LEVEL_BITS){1'b0}}, brightness, 32'h0};
            // red, green, blue then two zero pad bytes
            4'(CAT_WBAL):      field = {{(HALF_BITS-LEVEL_BITS){1'b0}}, wb_red,
                                        {(HALF_BITS-LEVEL_BITS){1'b0}}, wb_green,
                                        {(HALF_BITS-LEVEL_BITS){1'b0}}, wb_blue, 16'h0};
            4'(CAT_FRAMECNT):  field = {frame_count, 32'h0};
            4'(CAT_TRIGCNT):   field = {trigger_count, 32'h0};
            4'(CAT_LINEIO):    field = {line_io, 32'h0};
            4'(CAT_ROI):       field = {roi_col, roi_row, roi_length, roi_width};
            default:           field = '0;
        endcase
        byte_out = field[63 - BYTE_BITS*idx -: BYTE_BITS];
    end
endmodule
`default_nettype wire

// ===== testbench/frame_metadata_embedder_chk.sv
// Purpose: port assertions for the metadata embedder
// Assumes: one clock, sync active-high reset
// Notes:   bound into every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module frame_metadata_embedder_chk
    import meta_embed_pkg::*;
#(
    parameter int PIX_W = 16
)
(
    input wire logic                core_clk,
    input wire logic                reset,
    input wire logic                embed_enable,
    input wire logic [NUM_CATS-1:0] cat_select,
    input wire logic [31:0]         timestamp,
    input wire logic [PIX_W-1:0]    in_data,
    input wire logic                in_sof,
    input wire logic                in_eol,
    input wire logic                in_valid,
    input wire logic                in_ready,
    input wire logic [PIX_W-1:0]    out_data,
    input wire logic                out_sof,
    input wire logic                out_eol,
    input wire logic                out_valid,
    input wire logic                out_ready
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // ----------------------------------------
    // handshake steps
    // ----------------------------------------
    sequence taken_s;
        in_valid && in_ready;
    endsequence
    sequence sof_on_s;
        taken_s ##0 (in_sof && embed_enable);
    endsequence
    hold_out_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output changed while stalled");
    ready_rule_a: assert property (in_ready == (!out_valid || out_ready))
        else $error("input ready does not follow output stall");
    one_lat_a: assert property (taken_s |=> out_valid)
        else $error("taken word not presented next cycle");
    sof_pass_a: assert property (taken_s |=> out_sof == $past(in_sof))
        else $error("start of frame not passed through");
    eol_pass_a: assert property (taken_s |=> out_eol == $past(in_eol))
        else $error("end of line not passed through");
    ts_first_a: assert property (sof_on_s ##0 cat_select[0] |=> out_data == PIX_W'(timestamp[31:24]))
        else $error("first word is not timestamp top byte");
    gain_hi_a: assert property (sof_on_s ##0 (cat_select == 9'h002) |=> out_data == '0)
        else $error("gain top byte not zero");
    off_pass_a: assert property (taken_s ##0 (in_sof && !embed_enable) |=> out_data == $past(in_data))
        else $error("disabled frame altered");
    none_pass_a: assert property (taken_s ##0 (in_sof && cat_select == '0) |=> out_data == $past(in_data))
        else $error("frame altered with nothing selected");
endmodule
bind frame_metadata_embedder frame_metadata_embedder_chk #(.PIX_W(PIX_W)) u_chk (.core_clk, .reset,
    .embed_enable, .cat_select, .timestamp, .in_data, .in_sof, .in_eol, .in_valid, .in_ready, .out_data,
    .out_sof, .out_eol, .out_valid, .out_ready);
`default_nettype wire

// ===== testbench/stream_sink_model.sv
// Purpose: transport-side sink that collects output words
// Assumes: stall gives ready one cycle in four
// Notes:   words kept as {sof, eol, data}
`timescale 1ns/10ps
`default_nettype none
module stream_sink_model #(
    parameter int PIX_W = 16
)
(
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             stall,
    input wire logic [PIX_W-1:0] out_data,
    input wire logic             out_sof,
    input wire logic             out_eol,
    input wire logic             out_valid,
    output logic                 out_ready
);
    logic [1:0]       phase_q = 2'h0;
    logic [PIX_W+1:0] words[$];
    // ready is driven only here; it stays low while reset is held
    always @(posedge core_clk)
    begin
        phase_q <= reset ? 2'h0 : phase_q + 2'h1;
        out_ready <= !reset && (!stall || phase_q == 2'h3);
        if (!reset && out_valid && out_ready)
            words.push_back({out_sof, out_eol, out_data});
    end
endmodule
`default_nettype wire

// ===== testbench/frame_metadata_embedder_tb_top.sv
// Purpose: self-checking bench for the metadata embedder
// Assumes: metadata values held for the whole run
// Notes:   frames of 48 words (one of 20 in t_short), lines of 16, so metadata spills
`timescale 1ns/10ps
`default_nettype none
module frame_metadata_embedder_tb_top;
    import meta_embed_pkg::*;
    localparam int PIX_W = 16;
    localparam int FRAME = 48;
    localparam int LINE  = 16;
    logic                  core_clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  embed_enable = 1'b0;
    logic [NUM_CATS-1:0]   cat_select = '0;
    logic [31:0]           timestamp = 32'h1a2b3c4d;
    logic [GAIN_BITS-1:0]  gain = 10'h3a5;
    logic [31:0]           exposure_us = 32'h0001e240;
    logic [LEVEL_BITS-1:0] brightness = 12'hfed;
    logic [LEVEL_BITS-1:0] wb_red = 12'h123;
    logic [LEVEL_BITS-1:0] wb_green = 12'h456;
    logic [LEVEL_BITS-1:0] wb_blue = 12'h789;
    logic [31:0]           frame_count = 32'hfffffffe;
    logic [31:0]           trigger_count = 32'h80000001;
    logic [31:0]           line_io = 32'h0000005a;
    logic [15:0]           roi_col = 16'h0102, roi_row = 16'h0304, roi_length = 16'h0506, roi_width = 16'h0708;
    logic [PIX_W-1:0]      in_data = '0;
    logic                  in_sof = 1'b0, in_eol = 1'b0, in_valid = 1'b0, stall = 1'b0;
    logic                  in_ready, out_sof, out_eol, out_valid, out_ready;
    logic [PIX_W-1:0]      out_data;
    logic [7:0]            exp_q[$];
    int                    fails = 0;
    int                    num_checks = 0;
    frame_metadata_embedder #(.PIX_W(PIX_W)) u_dut (.core_clk, .reset, .embed_enable, .cat_select, .timestamp,
        .gain, .exposure_us, .brightness, .wb_red, .wb_green, .wb_blue, .frame_count, .trigger_count, .line_io,
        .roi_col, .roi_row, .roi_length, .roi_width, .in_data, .in_sof, .in_eol, .in_valid, .in_ready,
        .out_data, .out_sof, .out_eol, .out_valid, .out_ready);
    stream_sink_model #(.PIX_W(PIX_W)) u_sink (.core_clk, .reset, .stall, .out_data, .out_sof, .out_eol,
        .out_valid, .out_ready);
    initial forever #50 core_clk = ~core_clk;
    // ----------------------------------------
    // expected metadata bytes
    // ----------------------------------------
    function automatic void push(logic [63:0] v, int n);
        for (int i = n - 1; i >= 0; i--)
            exp_q.push_back(v[i*8+:8]);
    endfunction
    function automatic void fill(logic [NUM_CATS-1:0] sel);
        exp_q.delete();
        if (sel[CAT_TIMESTAMP]) push(64'(timestamp), 4);
        if (sel[CAT_GAIN]) push(64'(gain), 4);
        if (sel[CAT_EXPOSURE]) push(64'(exposure_us), 4);
        if (sel[CAT_BRIGHT]) push(64'(brightness), 4);
        if (sel[CAT_WBAL]) push({4'h0, wb_red, 4'h0, wb_green, 4'h0, wb_blue, 16'h0}, 8);
        if (sel[CAT_FRAMECNT]) push(64'(frame_count), 4);
        if (sel[CAT_TRIGCNT]) push(64'(trigger_count), 4);
        if (sel[CAT_LINEIO]) push(64'(line_io), 4);
        if (sel[CAT_ROI]) push({roi_col, roi_row, roi_length, roi_width}, 8);
    endfunction
    // ----------------------------------------
    // one frame through, then word-by-word judgement
    // ----------------------------------------
    task automatic run(logic en, logic [NUM_CATS-1:0] sel, logic slow, int n);
        int               w;
        logic [PIX_W+1:0] want;
        embed_enable <= en;
        cat_select <= sel;
        stall <= slow;
        u_sink.words.delete();
        exp_q.delete();
        if (en) fill(sel);
        for (int i = 0; i < n; i++)
        begin
            in_valid <= 1'b1;
            in_sof <= (i == 0);
            in_eol <= (i % LINE == LINE - 1);
            in_data <= PIX_W'(16'ha000 + i);
            @(negedge core_clk);
            while (!in_ready) @(negedge core_clk);
            @(posedge core_clk);
        end
        in_valid <= 1'b0;
        w = 0;
        while (u_sink.words.size() < n && w < 1000)
        begin
            @(posedge core_clk);
            w++;
        end
        for (int i = 0; i < n; i++)
        begin
            want = {i == 0, i % LINE == LINE - 1, i < exp_q.size() ? PIX_W'(exp_q[i]) : PIX_W'(16'ha000 + i)};
            num_checks++;
            if (i >= u_sink.words.size() || u_sink.words[i] !== want)
            begin
                fails++;
                $display("[FAIL] %0t word %0d got %h want %h", $time, i, u_sink.words[i], want);
            end
        end
    endtask
    task automatic t_all_slow();
        run(1'b1, 9'h1ff, 1'b1, FRAME);
    endtask
    // a frame shorter than its metadata; the next sof must restart the sequence
    task automatic t_short();
        run(1'b1, 9'h1ff, 1'b0, 20);
        run(1'b1, 9'h001, 1'b0, FRAME);
    endtask
    task automatic t_each();
        for (int c = 0; c < NUM_CATS; c++)
            run(1'b1, NUM_CATS'(1) << c, 1'b0, FRAME);
    endtask
    task automatic t_bypass();
        run(1'b0, 9'h1ff, 1'b0, FRAME);
        run(1'b1, 9'h000, 1'b1, FRAME);
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_all_slow();
        t_each();
        t_short();
        t_bypass();
        wrap_up();
    end
    // about 1000 cycles expected, generous margin
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
